// ===== src/bil_regs.svh
// Constants of the boot image loader: flash layout, SRAM placement, checksum setup.
// Assumes byte addressing and halfword-wide flash reads.
`ifndef BIL_REGS_SVH
`define BIL_REGS_SVH

// Flash is seen through a 64K byte window; the page selects which 64K of flash shows.
`define BIL_WIN_BASE 32'h0100_0000
`define BIL_WIN_SPAN 32'h0001_0000
// One program slot is two sectors of 64KB each.
`define BIL_SECTOR_BYTES 23'h01_0000
`define BIL_SLOT_BYTES 23'h02_0000
`define BIL_NUM_SLOTS 3'h4
// Largest payload in bytes; the stored checksum follows it directly.
`define BIL_PAYLOAD_BYTES 17'h1_67FE
`define BIL_CRC_OFS 17'h1_67FE
// Halfword indices: last payload halfword and the stored checksum halfword.
`define BIL_LAST_COPY_IDX 17'h0_B3FE
`define BIL_LAST_CHECK_IDX 17'h0_B3FF
// Override record at the start of sector 9: image number, then its checksum.
`define BIL_OVR_OFS 23'h09_0000
`define BIL_OVR_LAST_IDX 17'h0_0001
// Destination SRAM.
`define BIL_SRAM_BASE 32'h2000_0000
`define BIL_SRAM_BYTES 32'h0001_8000
// Fixed checksum algorithm: polynomial 0x1021, preset all ones, most significant bit first.
`define BIL_CRC_POLY 16'h1021
`define BIL_CRC_INIT 16'hFFFF
// Copy FIFO depth in halfword writes.
`define BIL_FIFO_DEPTH 32

`endif

// ===== src/bil_pkg.sv
// Types shared by the boot image loader and its copy FIFO.
// Assumes the constants header is available on the include path.
`default_nettype none
package bil_pkg;

  // Loader sequence states.
  typedef enum logic [2:0] {
    BIL_ST_OVR = 3'b000,
    BIL_ST_PICK = 3'b001,
    BIL_ST_CHECK = 3'b010,
    BIL_ST_COPY = 3'b011,
    BIL_ST_DRAIN = 3'b100,
    BIL_ST_RUN = 3'b101,
    BIL_ST_FAIL = 3'b110
  } bil_state_t;

  // One halfword write toward SRAM.
  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] data;
  } bil_sram_wr_t;

  // One halfword read request toward the flash window.
  typedef struct packed {
    logic [6:0] page;
    logic [31:0] addr;
  } bil_flash_req_t;

endpackage
`default_nettype wire

// ===== src/bil_fifo.sv
// Synchronous FIFO with valid/ready on both sides, used in the copy path.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module bil_fifo #(
  parameter int W = 48,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0] wr_ptr_q;
  logic [AW:0] rd_ptr_q;
  logic full;
  logic empty;

  // Full when pointers differ only in the wrap bit, empty when equal.
  assign empty = (wr_ptr_q == rd_ptr_q);
  assign full = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem_q[rd_ptr_q[AW-1:0]];

  // Storage write.
  always_ff @(posedge clk) begin
    if (in_valid && !full) begin
      mem_q[wr_ptr_q[AW-1:0]] <= in_data;
    end
  end

  // Pointer update.
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (in_valid && !full) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end

endmodule // bil_fifo

`default_nettype wire

// ===== src/bil_loader.sv
// Boot image loader: picks a valid image in flash and copies it into SRAM.
// Assumes a flash port answering each accepted read with one halfword, and an SRAM write port.
//
// Overview of operation
// - After reset, copy a selected image from flash to SRAM, then start it.
// - Four slots, each two 64KB sectors, addressed by image number.
// - Payload is at most 0x167FE bytes from slot base; only that span used.
// - Sixteen-bit checksum stored at offset 0x167FE in each slot.
// - Image valid only when computed checksum equals the stored one.
// - Read the four-byte override record at sector 9 before choosing.
// - Override holds image number halfword and a checksum halfword over it.
// - Good override naming a valid image is tried before any other.
// - Otherwise test slots upward from image 0, load first valid one.
// - All flash reads go through the 64K window at 0x0100_0000.
// - Image is placed from the start of the 96KB SRAM.
`timescale 1ns/1ps
`default_nettype none
`include "bil_regs.svh"

module bil_loader (
  input wire logic clk,
  input wire logic reset,
  output logic fl_req_valid,
  input wire logic fl_req_ready,
  output bil_pkg::bil_flash_req_t fl_req,
  input wire logic fl_rsp_valid,
  input wire logic [15:0] fl_rsp_data,
  output logic sram_valid,
  input wire logic sram_ready,
  output bil_pkg::bil_sram_wr_t sram_wr,
  output logic boot_start,
  output logic [31:0] boot_entry,
  output logic boot_done,
  output logic boot_fail,
  output logic [1:0] boot_image
);
  import bil_pkg::*;

  bil_state_t state_q;
  logic busy_q;
  logic [16:0] idx_q;
  logic [15:0] crc_q;
  logic [15:0] ovr_num_q;
  logic ovr_ok_q;
  logic ovr_tried_q;
  logic [2:0] search_q;
  logic [1:0] slot_q;
  logic start_q;
  logic [22:0] flash_off;
  logic [15:0] crc_next;
  logic [15:0] ovr_crc;
  logic fifo_in_ready;
  logic fifo_in_valid;
  bil_sram_wr_t fifo_in;
  logic [$bits(bil_sram_wr_t)-1:0] fifo_out;
  logic active;

  // One checksum step over a halfword, most significant bit first.
  function automatic logic [15:0] crc16_step(input logic [15:0] crc, input logic [15:0] data);
    logic [15:0] c;
    c = crc;
    for (int i = 15; i >= 0; i--) begin
      if (c[15] ^ data[i]) begin
        c = {c[14:0], 1'b0} ^ `BIL_CRC_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction

  assign crc_next = crc16_step(crc_q, fl_rsp_data);
  assign ovr_crc = crc16_step(`BIL_CRC_INIT, ovr_num_q);

  // Flash byte offset of the current halfword: override record or slot span.
  always_comb begin
    if (state_q == BIL_ST_OVR) begin
      flash_off = `BIL_OVR_OFS + {5'h00, idx_q, 1'b0};
    end else begin
      flash_off = (23'(slot_q) * `BIL_SLOT_BYTES) + {5'h00, idx_q, 1'b0};
    end
  end

  // Request goes out through the window; the page picks the 64K block shown there.
  assign fl_req.page = flash_off[22:16];
  assign fl_req.addr = `BIL_WIN_BASE | {16'h0000, flash_off[15:0]};

  // Copying waits for FIFO room, so a stalled SRAM holds back flash reads.
  // No read is offered during reset, so the flash never holds a stale request afterwards.
  assign active = (state_q == BIL_ST_OVR) || (state_q == BIL_ST_CHECK) ||
                  ((state_q == BIL_ST_COPY) && fifo_in_ready);
  assign fl_req_valid = active && !busy_q && !reset;

  // Copied halfwords are placed from the SRAM base upward.
  assign fifo_in.addr = `BIL_SRAM_BASE + {14'h0000, idx_q, 1'b0};
  assign fifo_in.data = fl_rsp_data;
  assign fifo_in_valid = (state_q == BIL_ST_COPY) && fl_rsp_valid && busy_q;

  // Outstanding read tracking: one read in flight at a time.
  always_ff @(posedge clk) begin
    if (reset) begin
      busy_q <= 1'b0;
    end else if (fl_req_valid && fl_req_ready) begin
      busy_q <= 1'b1;
    end else if (fl_rsp_valid) begin
      busy_q <= 1'b0;
    end
  end

  // Main sequence: override, selection, check, copy, start.
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= BIL_ST_OVR;
      idx_q <= '0;
      crc_q <= `BIL_CRC_INIT;
      ovr_num_q <= '0;
      ovr_ok_q <= 1'b0;
      ovr_tried_q <= 1'b0;
      search_q <= '0;
      slot_q <= '0;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      case (state_q)
        BIL_ST_OVR: begin
          if (fl_rsp_valid && busy_q) begin
            if (idx_q == `BIL_OVR_LAST_IDX) begin
              // Second halfword is the checksum over the image number.
              ovr_ok_q <= (ovr_crc == fl_rsp_data) && (ovr_num_q < 16'(`BIL_NUM_SLOTS));
              idx_q <= '0;
              state_q <= BIL_ST_PICK;
            end else begin
              ovr_num_q <= fl_rsp_data;
              idx_q <= idx_q + 17'h0_0001;
            end
          end
        end
        BIL_ST_PICK: begin
          crc_q <= `BIL_CRC_INIT;
          idx_q <= '0;
          if (ovr_ok_q && !ovr_tried_q) begin
            slot_q <= ovr_num_q[1:0];
            ovr_tried_q <= 1'b1;
            state_q <= BIL_ST_CHECK;
          end else if (search_q < `BIL_NUM_SLOTS) begin
            search_q <= search_q + 3'h1;
            // The override slot already failed, so the search passes it by.
            if (!(ovr_ok_q && (ovr_num_q[2:0] == search_q))) begin
              slot_q <= search_q[1:0];
              state_q <= BIL_ST_CHECK;
            end
          end else begin
            state_q <= BIL_ST_FAIL;
          end
        end
        BIL_ST_CHECK: begin
          if (fl_rsp_valid && busy_q) begin
            if (idx_q == `BIL_LAST_CHECK_IDX) begin
              // Last halfword read is the stored checksum.
              idx_q <= '0;
              state_q <= (crc_q == fl_rsp_data) ? BIL_ST_COPY : BIL_ST_PICK;
            end else begin
              crc_q <= crc_next;
              idx_q <= idx_q + 17'h0_0001;
            end
          end
        end
        BIL_ST_COPY: begin
          if (fl_rsp_valid && busy_q) begin
            if (idx_q == `BIL_LAST_COPY_IDX) begin
              state_q <= BIL_ST_DRAIN;
            end else begin
              idx_q <= idx_q + 17'h0_0001;
            end
          end
        end
        BIL_ST_DRAIN: begin
          // Start only after every copied halfword has reached SRAM.
          if (!sram_valid) begin
            start_q <= 1'b1;
            state_q <= BIL_ST_RUN;
          end
        end
        BIL_ST_RUN: begin
          state_q <= BIL_ST_RUN;
        end
        BIL_ST_FAIL: begin
          state_q <= BIL_ST_FAIL;
        end
        default: begin
          state_q <= BIL_ST_FAIL;
        end
      endcase
    end
  end

  // Status outputs.
  assign boot_start = start_q;
  assign boot_entry = `BIL_SRAM_BASE;
  assign boot_done = (state_q == BIL_ST_RUN);
  assign boot_fail = (state_q == BIL_ST_FAIL);
  assign boot_image = slot_q;

  // Copy FIFO between flash responses and SRAM writes.
  bil_fifo #(
    .W($bits(bil_sram_wr_t)),
    .DEPTH(`BIL_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(sram_valid),
    .out_ready(sram_ready),
    .out_data(fifo_out)
  );

  assign sram_wr = bil_sram_wr_t'(fifo_out);

endmodule // bil_loader

`default_nettype wire

// ===== verif/bil_tb_pkg.sv
// Reference payload pattern and checksum step for the loader bench.
// Assumes nothing beyond plain SystemVerilog.
`default_nettype none
package bil_tb_pkg;
  // Payload halfword of a slot at a halfword index.
  function automatic logic [15:0] bil_pat(input logic [1:0] s, input logic [16:0] i);
    return i[15:0] ^ {s, 14'h0A5C};
  endfunction
  // One halfword step of the checksum, most significant bit first.
  function automatic logic [15:0] bil_crc(input logic [15:0] c, input logic [15:0] d);
    for (int b = 15; b >= 0; b--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[b]) ? 16'h1021 : 16'h0000);
    end
    return c;
  endfunction
endpackage
`default_nettype wire

// ===== verif/bil_flash_model.sv
// Flash array model: four slot images and an override record.
// Assumes the bench sets record, slot soundness and answer latency.
`timescale 1ns/1ps
`default_nettype none
module bil_flash_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic fl_req_valid,
  output logic fl_req_ready,
  input wire bil_pkg::bil_flash_req_t fl_req,
  output logic fl_rsp_valid,
  output logic [15:0] fl_rsp_data,
  input wire logic [15:0] ovr_num,
  input wire logic ovr_good,
  input wire logic [3:0] good_mask,
  input wire logic [1:0] lat
);
  import bil_tb_pkg::*;
  logic [15:0] crc_tab [4];
  logic [22:0] ofs_q;
  logic [1:0] cnt_q;
  logic [1:0] tick_q;
  // Checksum of every slot payload, worked out once.
  initial begin
    for (int s = 0; s < 4; s++) begin
      crc_tab[s] = 16'hFFFF;
      for (int i = 0; i < 32'h0000_B3FF; i++) begin
        crc_tab[s] = bil_crc(crc_tab[s], bil_pat(2'(s), 17'(i)));
      end
    end
  end
  // Content of one flash byte offset; a bad slot has bit 0 of its stored checksum flipped.
  function automatic logic [15:0] rd(input logic [22:0] o);
    logic [15:0] oc;
    oc = bil_crc(16'hFFFF, ovr_num);
    if (o == 23'h09_0000) return ovr_num;
    if (o == 23'h09_0002) return ovr_good ? oc : ~oc;
    if (o[16:1] == 16'hB3FF) return crc_tab[o[18:17]] ^ {15'h0000, ~good_mask[o[18:17]]};
    return bil_pat(o[18:17], {1'b0, o[16:1]});
  endfunction
  // Ready drops one cycle in four; idle data toggles so it never looks held.
  assign fl_req_ready = (cnt_q == 2'h0) && (tick_q != 2'h3);
  // One read in flight, answered lat cycles after acceptance.
  always_ff @(posedge clk) begin
    tick_q <= reset ? 2'h0 : tick_q + 2'h1;
    // The answer goes out as the countdown ends; ready is low then, so no accept collides.
    fl_rsp_valid <= !reset && (cnt_q == 2'h1);
    if (reset) begin
      fl_rsp_data <= 16'h5A5A;
    end else if (cnt_q == 2'h1) begin
      fl_rsp_data <= rd(ofs_q);
    end else begin
      fl_rsp_data <= ~fl_rsp_data;
    end
    if (reset) begin
      cnt_q <= 2'h0;
    end else if (fl_req_valid && fl_req_ready) begin
      cnt_q <= lat;
      ofs_q <= {fl_req.page, fl_req.addr[15:0]};
    end else if (cnt_q != 2'h0) begin
      cnt_q <= cnt_q - 2'h1;
    end
  end
endmodule // bil_flash_model
`default_nettype wire

// ===== verif/bil_loader_checker.sv
// Port assertions for the boot image loader.
// Assumes bil_pkg; bound into every bil_loader.
`timescale 1ns/1ps
`default_nettype none
module bil_loader_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic fl_req_valid,
  input wire logic fl_req_ready,
  input wire bil_pkg::bil_flash_req_t fl_req,
  input wire logic sram_valid,
  input wire logic sram_ready,
  input wire bil_pkg::bil_sram_wr_t sram_wr,
  input wire logic boot_start,
  input wire logic [31:0] boot_entry,
  input wire logic boot_done,
  input wire logic boot_fail,
  input wire logic [1:0] boot_image
);
  import bil_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Flash reads stay in the window, inside the slot being checked.
  AST_WINDOW: assert property (fl_req_valid |-> fl_req.addr[31:16] == 16'h0100)
    else $error("read outside window");
  AST_SLOT: assert property (fl_req_valid && fl_req.page != 7'h09 |-> fl_req.page[6:3] == 4'h0
    && fl_req.page[2:1] == boot_image && {fl_req.page[0], fl_req.addr[15:0]} <= 17'h1_67FE)
    else $error("read outside slot");
  AST_OVR_FIRST: assert property ($fell(reset) |-> fl_req_valid && fl_req.page == 7'h09
    && fl_req.addr == 32'h0100_0000) else $error("record not read first");
  AST_REQ_HOLD: assert property (fl_req_valid && !fl_req_ready |=> fl_req_valid && $stable(fl_req))
    else $error("read request dropped");
  // SRAM writes land inside the payload span from the SRAM base and hold until taken.
  AST_SRAM_MAP: assert property (sram_valid |-> sram_wr.addr >= 32'h2000_0000
    && sram_wr.addr < 32'h2001_67FE && !sram_wr.addr[0]) else $error("write outside image");
  AST_SRAM_HOLD: assert property (sram_valid && !sram_ready |=> sram_valid && $stable(sram_wr))
    else $error("write dropped");
  // Start is one pulse at the SRAM base after the copy drains; failure never starts.
  AST_START: assert property (boot_start |-> (boot_entry == 32'h2000_0000 && !sram_valid)
    ##1 (!boot_start && boot_done)) else $error("bad start");
  AST_FAIL: assert property (boot_fail |-> !boot_start && !boot_done && !fl_req_valid)
    else $error("started after failure");
  cover property (boot_start);
  cover property (boot_fail);
  cover property (sram_valid && !sram_ready [*8]);
endmodule // bil_loader_checker
bind bil_loader bil_loader_checker u_bil_loader_checker (.clk(clk), .reset(reset),
  .fl_req_valid(fl_req_valid), .fl_req_ready(fl_req_ready), .fl_req(fl_req),
  .sram_valid(sram_valid), .sram_ready(sram_ready), .sram_wr(sram_wr),
  .boot_start(boot_start), .boot_entry(boot_entry), .boot_done(boot_done),
  .boot_fail(boot_fail), .boot_image(boot_image));
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench: loader, flash model and a stalling SRAM sink.
// Assumes design, bil_tb_pkg and model compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import bil_tb_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic sram_ready = 1'b0;
  logic ovr_good = 1'b0;
  logic fl_req_valid, fl_req_ready, fl_rsp_valid, sram_valid, boot_start, boot_done, boot_fail;
  logic first_seen;
  logic [1:0] boot_image, first_slot;
  logic [1:0] lat = 2'h1;
  logic [1:0] exp_slot = 2'h0;
  logic [15:0] fl_rsp_data;
  logic [15:0] ovr_num = 16'h0000;
  logic [3:0] good_mask = 4'h0;
  logic [31:0] boot_entry;
  logic [8:0] tick = 9'h000;
  bil_pkg::bil_flash_req_t fl_req;
  bil_pkg::bil_sram_wr_t sram_wr;
  int error_cnt = 0;
  int samples_checked = 0;
  int wr_cnt, starts;
  initial forever #5 clk = ~clk;
  bil_loader u_bil_loader (.clk(clk), .reset(reset), .fl_req_valid(fl_req_valid),
    .fl_req_ready(fl_req_ready), .fl_req(fl_req), .fl_rsp_valid(fl_rsp_valid),
    .fl_rsp_data(fl_rsp_data), .sram_valid(sram_valid), .sram_ready(sram_ready),
    .sram_wr(sram_wr), .boot_start(boot_start), .boot_entry(boot_entry),
    .boot_done(boot_done), .boot_fail(boot_fail), .boot_image(boot_image));
  bil_flash_model u_bil_flash_model (.clk(clk), .reset(reset), .fl_req_valid(fl_req_valid),
    .fl_req_ready(fl_req_ready), .fl_req(fl_req), .fl_rsp_valid(fl_rsp_valid),
    .fl_rsp_data(fl_rsp_data), .ovr_num(ovr_num), .ovr_good(ovr_good),
    .good_mask(good_mask), .lat(lat));
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Sink stalls 128 cycles in 512 and takes every other cycle otherwise, so the copy FIFO fills; every write is judged.
  // The per-boot counters clear while the loader is held in reset.
  always @(posedge clk) begin
    tick <= tick + 9'h001;
    sram_ready <= (tick[8:7] != 2'h0) && tick[0];
    if (reset) begin
      wr_cnt <= 0;
      starts <= 0;
      first_seen <= 1'b0;
    end else begin
      if (sram_valid && sram_ready) begin
        check("sram addr", 48'(sram_wr.addr), 48'(32'h2000_0000 + 2 * wr_cnt));
        check("sram data", 48'(sram_wr.data), 48'(bil_pat(exp_slot, 17'(wr_cnt))));
        wr_cnt <= wr_cnt + 1;
      end
      if (boot_start) begin
        starts <= starts + 1;
      end
      if (!first_seen && fl_req_valid && fl_req_ready && fl_req.page != 7'h09) begin
        first_seen <= 1'b1;
        first_slot <= fl_req.page[2:1];
      end
    end
  end
  // Resets the loader on the given flash contents and waits, bounded, for it to settle.
  task automatic boot(input logic [15:0] num, input logic good, input logic [3:0] mask,
                      input logic [1:0] l, input logic [1:0] slot);
    int n;
    reset <= 1'b1;
    ovr_num <= num;
    ovr_good <= good;
    good_mask <= mask;
    lat <= l;
    exp_slot <= slot;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    for (n = 0; n < 32'h0016_E360 && boot_done !== 1'b1 && boot_fail !== 1'b1; n++) @(posedge clk);
    if (n == 32'h0016_E360) begin
      error_cnt++;
      give_verdict();
    end
    repeat (4) @(posedge clk);
  endtask
  // Common judgement of one boot: first slot tried, image, writes, start and flags.
  task automatic judge(input logic [1:0] first, input logic [1:0] flags, input int writes);
    check("first slot", 48'(first_slot), 48'(first));
    if (flags[1]) check("image", 48'(boot_image), 48'(exp_slot));
    check("writes", 48'(wr_cnt), 48'(writes));
    check("starts", 48'(starts), 48'(flags[1]));
    check("done fail", 48'({boot_done, boot_fail}), 48'(flags));
    check("entry", 48'(boot_entry), 48'h2000_0000);
  endtask
  // Sound record naming slot 2, all slots sound: slot 2 goes first and is copied.
  task automatic run_override();
    boot(16'h0002, 1'b1, 4'hF, 2'h1, 2'h2);
    judge(2'h2, 2'h2, 32'h0000_B3FF);
  endtask
  // Corrupt record, slot 0 bad, slot 1 sound, slow answers: search from slot 0 finds 1.
  task automatic run_search();
    boot(16'h0001, 1'b0, 4'h2, 2'h2, 2'h1);
    judge(2'h0, 2'h2, 32'h0000_B3FF);
  endtask
  // Sound record naming slot 3 but no sound slot anywhere: failure, nothing copied.
  task automatic run_no_image();
    boot(16'h0003, 1'b1, 4'h0, 2'h1, 2'h0);
    judge(2'h3, 2'h1, 0);
  endtask
  initial begin
    run_override();
    run_search();
    run_no_image();
    give_verdict();
  end
endmodule // tb
`default_nettype wire
